// ==== logic/csb_unit.sv ====
/*
 * Compare, skip and conditional branch execution unit of an 8-bit core.
 * A decoded command is taken in one cycle, its operands are read from
 * the register store, and it executes in the next cycle, updating the
 * status flags or the program counter.
 * Assumes the fetch side presents the instruction stream back to back
 * and refetches from pc_out whenever redirect pulses.
 */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module csb_unit
    import csb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire csb_cmd_type cmd,
    output var  logic        cmd_ready,
    input  wire csb_bus_type host,
    output var  logic [7:0]  host_rdata,
    output var  logic [15:0] pc_out,
    output var  logic [7:0]  flags_out,
    output var  logic        redirect,
    output var  logic        exec_done
);

    logic              cmd_ready_r;
    logic              cmd_ready_nxt;
    logic [7:0]        host_rdata_r;
    logic [7:0]        host_rdata_nxt;
    logic [15:0]       pc_r;
    logic [15:0]       pc_nxt;
    logic [7:0]        flags_r;
    logic [7:0]        flags_nxt;
    logic              redirect_r;
    logic              redirect_nxt;
    logic              done_r;
    logic              done_nxt;
    logic              ex_valid_r;
    logic              ex_valid_nxt;
    csb_cmd_type       ex_cmd_r;
    csb_cmd_type       ex_cmd_nxt;
    csb_state_type     state_r;
    csb_state_type     state_nxt;

    logic              accept;
    logic              io_read;
    logic [MEM_AW-1:0] addr_a;
    logic [MEM_AW-1:0] addr_b;
    logic [7:0]        opnd_a;
    logic [7:0]        opnd_b;
    logic              mem_we;

    logic [7:0]        sub_rhs;
    logic              sub_cin;
    logic [7:0]        diff;
    logic              is_compare;
    logic              is_skip;
    logic              is_branch;
    logic              cond;
    logic [15:0]       skip_step;
    logic [15:0]       branch_target;

    assign accept = cmd_valid & cmd_ready_r;
    assign io_read = (cmd.op == op_skip_io_bit_low) || (cmd.op == op_skip_io_bit_high);
    assign addr_a = {REG_SPACE, cmd.rd};
    assign addr_b = io_read ? {IO_SPACE, cmd.io_addr} : {REG_SPACE, cmd.rr};
    assign mem_we = host.wr && (host.addr <= ADDR_MEM_LAST);

    csb_reg_mem u_mem (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .waddr   (host.addr[MEM_AW-1:0]),
        .wdata   (host.wdata),
        .raddr_a (addr_a),
        .raddr_b (addr_b),
        .rdata_a (opnd_a),
        .rdata_b (opnd_b)
    );

    // Operand selection and subtraction shared by the three compares.
    always_comb begin
        is_compare = 1'b0;
        is_skip    = 1'b0;
        is_branch  = 1'b0;
        sub_rhs    = opnd_b;
        sub_cin    = 1'b0;
        cond       = 1'b0;
        case (ex_cmd_r.op)
            op_compare_regs: begin
                is_compare = 1'b1;
            end
            op_compare_regs_with_borrow: begin
                is_compare = 1'b1;
                sub_cin    = flags_r[FLAG_C];
            end
            op_compare_immediate: begin
                is_compare = 1'b1;
                sub_rhs    = ex_cmd_r.imm;
            end
            op_skip_reg_bit_low, op_skip_io_bit_low: begin
                is_skip = 1'b1;
                cond    = ~opnd_b[ex_cmd_r.bit_sel];
            end
            op_skip_reg_bit_high, op_skip_io_bit_high: begin
                is_skip = 1'b1;
                cond    = opnd_b[ex_cmd_r.bit_sel];
            end
            op_branch_status_bit_high: begin
                is_branch = 1'b1;
                cond      = flags_r[ex_cmd_r.bit_sel];
            end
            op_branch_status_bit_low: begin
                is_branch = 1'b1;
                cond      = ~flags_r[ex_cmd_r.bit_sel];
            end
            op_branch_when_zero: begin
                is_branch = 1'b1;
                cond      = flags_r[FLAG_Z];
            end
            op_branch_when_nonzero: begin
                is_branch = 1'b1;
                cond      = ~flags_r[FLAG_Z];
            end
            op_branch_when_carry, op_branch_unsigned_lt: begin
                is_branch = 1'b1;
                cond      = flags_r[FLAG_C];
            end
            op_branch_when_no_carry, op_branch_unsigned_ge: begin
                is_branch = 1'b1;
                cond      = ~flags_r[FLAG_C];
            end
            op_branch_when_negative: begin
                is_branch = 1'b1;
                cond      = flags_r[FLAG_N];
            end
            op_branch_when_positive: begin
                is_branch = 1'b1;
                cond      = ~flags_r[FLAG_N];
            end
            op_branch_signed_ge: begin
                is_branch = 1'b1;
                cond      = ~(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
            end
            op_branch_signed_lt: begin
                is_branch = 1'b1;
                cond      = flags_r[FLAG_N] ^ flags_r[FLAG_V];
            end
            default: begin
                is_compare = 1'b0;
            end
        endcase
    end

    assign diff = opnd_a - sub_rhs - {7'h00, sub_cin};

    assign skip_step = ex_cmd_r.succ_two_word ? SKIP_TWO_WORD : SKIP_ONE_WORD;

    assign branch_target = pc_r + {{9{ex_cmd_r.offset[6]}}, ex_cmd_r.offset} + PC_STEP;

    // Sequencing, flags and program counter.
    always_comb begin
        flags_nxt     = flags_r;
        pc_nxt        = pc_r;
        redirect_nxt  = 1'b0;
        done_nxt      = 1'b0;
        state_nxt     = st_run;
        cmd_ready_nxt = 1'b1;
        ex_valid_nxt  = accept;
        ex_cmd_nxt    = accept ? cmd : ex_cmd_r;
        if (host.wr && host.addr == ADDR_FLAGS) begin
            flags_nxt = host.wdata;
        end
        if (host.wr && host.addr == ADDR_PC_LO) begin
            pc_nxt[7:0] = host.wdata;
        end
        if (host.wr && host.addr == ADDR_PC_HI) begin
            pc_nxt[15:8] = host.wdata;
        end
        if (ex_valid_r) begin
            done_nxt = 1'b1;
            pc_nxt   = pc_r + PC_STEP;
            if (is_compare) begin
                flags_nxt[FLAG_N] = diff[MSB];
                flags_nxt[FLAG_H] = (~opnd_a[HALF] & sub_rhs[HALF]) | (sub_rhs[HALF] & diff[HALF])
                                  | (diff[HALF] & ~opnd_a[HALF]);
                flags_nxt[FLAG_C] = (~opnd_a[MSB] & sub_rhs[MSB]) | (sub_rhs[MSB] & diff[MSB])
                                  | (diff[MSB] & ~opnd_a[MSB]);
                flags_nxt[FLAG_V] = (opnd_a[MSB] & ~sub_rhs[MSB] & ~diff[MSB])
                                  | (~opnd_a[MSB] & sub_rhs[MSB] & diff[MSB]);
                if (ex_cmd_r.op == op_compare_regs_with_borrow) begin
                    flags_nxt[FLAG_Z] = (diff == BYTE_ZERO) & flags_r[FLAG_Z];
                end else begin
                    flags_nxt[FLAG_Z] = (diff == BYTE_ZERO);
                end
            end
            if (is_skip && cond) begin
                pc_nxt       = pc_r + skip_step;
                redirect_nxt = 1'b1;
                ex_valid_nxt = 1'b0;
                if (ex_cmd_r.succ_two_word) begin
                    state_nxt     = st_stall;
                    cmd_ready_nxt = 1'b0;
                end
            end
            // Taken branch costs the flushed slot
            if (is_branch && cond) begin
                pc_nxt       = branch_target;
                redirect_nxt = 1'b1;
                ex_valid_nxt = 1'b0;
            end
        end
        case (state_r)
            st_run: begin
                cmd_ready_nxt = cmd_ready_nxt;
            end
            st_stall: begin
                cmd_ready_nxt = 1'b1;
            end
            default: begin
                state_nxt = st_run;
            end
        endcase
    end

    // Host read data, standing only in the cycle after the read strobe.
    always_comb begin
        host_rdata_nxt = BYTE_ZERO;
        if (host.rd) begin
            case (host.addr)
                ADDR_FLAGS: begin
                    host_rdata_nxt = flags_r;
                end
                ADDR_PC_LO: begin
                    host_rdata_nxt = pc_r[7:0];
                end
                ADDR_PC_HI: begin
                    host_rdata_nxt = pc_r[15:8];
                end
                ADDR_STATE: begin
                    host_rdata_nxt = {6'h00, state_r == st_stall, ex_valid_r};
                end
                default: begin
                    host_rdata_nxt = BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_ready_r  <= 1'b0;
            host_rdata_r <= BYTE_ZERO;
            pc_r         <= PC_RST;
            flags_r      <= FLAGS_RST;
            redirect_r   <= 1'b0;
            done_r       <= 1'b0;
            ex_valid_r   <= 1'b0;
            ex_cmd_r     <= '0;
            state_r      <= st_run;
        end else begin
            cmd_ready_r  <= cmd_ready_nxt;
            host_rdata_r <= host_rdata_nxt;
            pc_r         <= pc_nxt;
            flags_r      <= flags_nxt;
            redirect_r   <= redirect_nxt;
            done_r       <= done_nxt;
            ex_valid_r   <= ex_valid_nxt;
            ex_cmd_r     <= ex_cmd_nxt;
            state_r      <= state_nxt;
        end
    end

    assign cmd_ready  = cmd_ready_r;
    assign host_rdata = host_rdata_r;
    assign pc_out     = pc_r;
    assign flags_out  = flags_r;
    assign redirect   = redirect_r;
    assign exec_done  = done_r;

endmodule

`default_nettype wire

// ==== logic/csb_pkg.sv ====
/*
 * Shared constants and types of the compare, skip and branch unit:
 * flag positions, host port map, program counter steps, decoded
 * command layout, operation codes and sequencer states.
 * Assumes a decoder ahead of the unit that delivers decoded commands.
 */
`default_nettype none

package csb_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W   = 16;
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 64;

    // Positions of the bits inside status_flags.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam int MSB    = 7;
    localparam int HALF   = 3;

    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    // Host port map: working registers, then I/O registers, then control.
    localparam logic [7:0] ADDR_MEM_LAST = 8'h3F;
    localparam logic [7:0] ADDR_FLAGS    = 8'h40;
    localparam logic [7:0] ADDR_PC_LO    = 8'h41;
    localparam logic [7:0] ADDR_PC_HI    = 8'h42;
    localparam logic [7:0] ADDR_STATE    = 8'h43;
    localparam logic       IO_SPACE      = 1'b1;
    localparam logic       REG_SPACE     = 1'b0;

    // Program counter steps.
    localparam logic [15:0] PC_STEP       = 16'h0001;
    localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
    localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;

    typedef enum logic [4:0] {
        op_none                  = 5'h00,
        op_compare_regs          = 5'h01,
        op_compare_regs_with_borrow = 5'h02,
        op_compare_immediate     = 5'h03,
        op_skip_reg_bit_low      = 5'h04,
        op_skip_reg_bit_high     = 5'h05,
        op_skip_io_bit_low       = 5'h06,
        op_skip_io_bit_high      = 5'h07,
        op_branch_status_bit_high = 5'h08,
        op_branch_status_bit_low = 5'h09,
        op_branch_when_zero      = 5'h0A,
        op_branch_when_nonzero   = 5'h0B,
        op_branch_when_carry     = 5'h0C,
        op_branch_when_no_carry  = 5'h0D,
        op_branch_unsigned_ge    = 5'h0E,
        op_branch_unsigned_lt    = 5'h0F,
        op_branch_when_negative  = 5'h10,
        op_branch_when_positive  = 5'h11,
        op_branch_signed_ge      = 5'h12,
        op_branch_signed_lt      = 5'h13
    } csb_op_type;

    typedef enum logic {
        st_run   = 1'b0,
        st_stall = 1'b1
    } csb_state_type;

    typedef struct packed {
        csb_op_type op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [4:0] io_addr;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic [6:0] offset;
        logic       succ_two_word;
    } csb_cmd_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } csb_bus_type;

endpackage

`default_nettype wire

// ==== logic/csb_reg_mem.sv ====
/*
 * Storage for the working registers and the I/O registers: one write
 * port, two read ports whose data come out of registers one cycle later.
 * Assumes the write and read addresses are stable around the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module csb_reg_mem
    import csb_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              we,
    input  wire logic [MEM_AW-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [MEM_AW-1:0] raddr_a,
    input  wire logic [MEM_AW-1:0] raddr_b,
    output var  logic [7:0]        rdata_a,
    output var  logic [7:0]        rdata_b
);

    logic [7:0] mem [MEM_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end

endmodule

`default_nettype wire

// ==== test/csb_tb_pkg.sv ====
/* Branch outcome model shared by the bench and its checker.
   Assumes csb_pkg is compiled first. */
`default_nettype none
package csb_tb_pkg;
    import csb_pkg::*;
    function automatic logic csb_br_taken(input csb_op_type op, input logic [2:0] s, input logic [7:0] f);
        case (op)
            op_branch_status_bit_high: return f[s];
            op_branch_status_bit_low: return !f[s];
            op_branch_when_zero: return f[FLAG_Z];
            op_branch_when_nonzero: return !f[FLAG_Z];
            op_branch_when_carry, op_branch_unsigned_lt: return f[FLAG_C];
            op_branch_when_no_carry, op_branch_unsigned_ge: return !f[FLAG_C];
            op_branch_when_negative: return f[FLAG_N];
            op_branch_when_positive: return !f[FLAG_N];
            op_branch_signed_ge: return !(f[FLAG_N] ^ f[FLAG_V]);
            op_branch_signed_lt: return f[FLAG_N] ^ f[FLAG_V];
            default: return 1'h0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== test/csb_unit_properties.sv ====
/* Concurrent checks on the ports of csb_unit.
   Assumes it is bound into csb_unit: one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module csb_unit_props
    import csb_pkg::*, csb_tb_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire csb_cmd_type cmd,
    input wire logic        cmd_ready,
    input wire csb_bus_type host,
    input wire logic [7:0]  host_rdata,
    input wire logic [15:0] pc_out,
    input wire logic [7:0]  flags_out,
    input wire logic        redirect,
    input wire logic        exec_done
);
    logic take;
    logic is_cmp;
    logic is_skip;
    logic is_br;
    assign take = cmd_valid && cmd_ready;
    assign is_cmp = cmd.op inside {[op_compare_regs:op_compare_immediate]};
    assign is_skip = cmd.op inside {[op_skip_reg_bit_low:op_skip_io_bit_high]};
    assign is_br = cmd.op inside {[op_branch_status_bit_high:op_branch_signed_lt]};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // A command taken and not dropped as a bypassed successor.
    sequence s_run(kind);
        take && kind ##1 !redirect;
    endsequence
    property p_cmp_step;
        s_run(is_cmp) |=> exec_done && !redirect && pc_out == $past(pc_out) + PC_STEP;
    endproperty
    a_cmp_step: assert property (p_cmp_step)
        else $error("compare step wrong");
    property p_flow_flags;
        s_run(is_skip || is_br) ##0 !host.wr |=> $stable(flags_out);
    endproperty
    a_flow_flags: assert property (p_flow_flags)
        else $error("flags changed by skip or branch");
    property p_br_cond;
        s_run(is_br) |=> redirect == csb_br_taken($past(cmd.op, 2), $past(cmd.bit_sel, 2), $past(flags_out));
    endproperty
    a_br_cond: assert property (p_br_cond)
        else $error("branch decision wrong");
    property p_br_target;
        s_run(is_br) ##1 redirect |->
            pc_out == $past(pc_out) + {{9{$past(cmd.offset[6], 2)}}, $past(cmd.offset, 2)} + PC_STEP;
    endproperty
    a_br_target: assert property (p_br_target)
        else $error("branch target wrong");
    property p_br_fall;
        s_run(is_br) ##1 !redirect |-> exec_done && pc_out == $past(pc_out) + PC_STEP;
    endproperty
    a_br_fall: assert property (p_br_fall)
        else $error("untaken branch step wrong");
    property p_skip_amt;
        s_run(is_skip) ##1 redirect |->
            pc_out == $past(pc_out) + ($past(cmd.succ_two_word, 2) ? SKIP_TWO_WORD : SKIP_ONE_WORD);
    endproperty
    a_skip_amt: assert property (p_skip_amt)
        else $error("skip amount wrong");
    property p_skip_stall;
        s_run(is_skip && cmd.succ_two_word) ##1 redirect |-> !cmd_ready ##1 cmd_ready;
    endproperty
    a_skip_stall: assert property (p_skip_stall)
        else $error("two word skip stall wrong");
    property p_redir_done;
        redirect |-> exec_done;
    endproperty
    a_redir_done: assert property (p_redir_done)
        else $error("redirect without completion");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
/* Self-checking bench for csb_unit: reset, host port, compares, skips,
   branches and a branch followed at once by its successor.
   Assumes csb_pkg, csb_tb_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CSB_CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e); end end
module tb_top
    import csb_pkg::*, csb_tb_pkg::*;
;
    logic        sys_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        cmd_valid = 1'h0;
    csb_cmd_type cmd = '0;
    csb_bus_type host = '0;
    logic        cmd_ready;
    logic [7:0]  host_rdata;
    logic [15:0] pc_out;
    logic [7:0]  flags_out;
    logic        redirect;
    logic        exec_done;
    int          miscompares = 0;
    int          check_count = 0;
    logic [15:0] exp_pc;
    logic [7:0]  exp_fl;
    csb_op_type  cop [6] = '{op_compare_regs, op_compare_regs, op_compare_regs, op_compare_regs_with_borrow,
                             op_compare_regs_with_borrow, op_compare_immediate};
    logic [7:0]  ca [6] = '{8'h80, 8'h10, 8'h5A, 8'h05, 8'h05, 8'h00};
    logic [7:0]  cb [6] = '{8'h01, 8'h01, 8'h5A, 8'h04, 8'h04, 8'h01};
    logic [7:0]  cf [6] = '{8'hC0, 8'h00, 8'h00, 8'h03, 8'h01, 8'h02};

    always #2 sys_clk = ~sys_clk;

    csb_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .host(host), .host_rdata(host_rdata), .pc_out(pc_out), .flags_out(flags_out), .redirect(redirect),
        .exec_done(exec_done));

    // Expected compare flags; the S bit is masked out of every flags check after a command.
    function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f,
                                        input logic wb);
        logic [8:0] r;
        logic [4:0] h;
        r = {1'h0, a} - {1'h0, b} - {8'h00, wb & f[FLAG_C]};
        h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, wb & f[FLAG_C]};
        cmpf = f;
        cmpf[FLAG_C] = r[8];
        cmpf[FLAG_Z] = (r[7:0] == 8'h00) && (!wb || f[FLAG_Z]);
        cmpf[FLAG_N] = r[7];
        cmpf[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        cmpf[FLAG_H] = h[4];
    endfunction

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_out;
        miscompares++;
        $display("MISMATCH t=%0t wait ran out", $time);
        end_of_test();
    endtask

    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        host <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge sys_clk);
    endtask

    task automatic host_rd(input logic [7:0] a, input logic [7:0] e);
        host <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge sys_clk);
        host <= '0;
        #1;
        `CSB_CHK(host_rdata, e, "host read")
        @(posedge sys_clk);
    endtask

    task automatic set_state(input logic [15:0] p, input logic [7:0] f);
        host_wr(ADDR_PC_LO, p[7:0]);
        host_wr(ADDR_PC_HI, p[15:8]);
        host_wr(ADDR_FLAGS, f);
        exp_pc = p;
        exp_fl = f;
    endtask

    task automatic take_cmd(input csb_cmd_type c);
        int n;
        host <= '0;
        cmd_valid <= 1'h1;
        cmd <= c;
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk);
            if (cmd_ready === 1'h1) break;
        end
        if (n == 8) wait_out();
    endtask

    task automatic run(input csb_cmd_type c, input logic redir);
        int n;
        take_cmd(c);
        cmd_valid <= 1'h0;
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk);
            #1;
            if (exec_done === 1'h1) break;
        end
        if (n == 8) wait_out();
        `CSB_CHK(redirect, redir, "redirect")
        `CSB_CHK(pc_out, exp_pc, "pc")
        `CSB_CHK(flags_out & 8'hEF, exp_fl & 8'hEF, "flags")
        @(posedge sys_clk);
    endtask

    initial begin
        csb_cmd_type c;
        int          i;
        int          n;
        logic        tk;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        #1;
        `CSB_CHK(pc_out, PC_RST, "reset pc")
        `CSB_CHK(flags_out, FLAGS_RST, "reset flags")
        `CSB_CHK({cmd_ready, redirect, exec_done, host_rdata}, 11'h400, "ready after reset")
        @(posedge sys_clk);
        set_state(16'h0100, 8'hC1);
        host_wr(8'hA0, 8'h55);
        host_rd(ADDR_FLAGS, 8'hC1);
        host_rd(ADDR_PC_HI, 8'h01);
        host_rd(ADDR_PC_LO, 8'h00);
        host_rd(ADDR_STATE, 8'h00);
        host_rd(8'h05, BYTE_ZERO);
        host_rd(8'hA0, BYTE_ZERO);
        for (i = 0; i < 6; i++) begin
            host_wr(8'h02, ca[i]);
            host_wr(8'h03, (cop[i] == op_compare_immediate) ? 8'hFF : cb[i]);
            set_state(exp_pc, cf[i]);
            c = '0;
            c.op = cop[i];
            c.rd = 5'h02;
            c.rr = 5'h03;
            c.imm = cb[i];
            exp_fl = cmpf(ca[i], cb[i], cf[i], cop[i] == op_compare_regs_with_borrow);
            exp_pc = exp_pc + PC_STEP;
            run(c, 1'h0);
        end
        host_wr(8'h04, 8'h20);
        host_wr(8'h24, 8'h04);
        for (i = 0; i < 16; i++) begin
            c = '0;
            c.op = csb_op_type'(5'h04 + 5'(i / 4));
            c.rd = 5'h04;
            c.rr = 5'h04;
            c.io_addr = 5'h04;
            c.bit_sel = i[1] ? 3'h5 : 3'h2;
            c.succ_two_word = i[0];
            tk = (i[1] == c.op[0]) ^ c.op[1];
            exp_pc = exp_pc + (tk ? (i[0] ? SKIP_TWO_WORD : SKIP_ONE_WORD) : PC_STEP);
            run(c, tk);
        end
        for (i = 0; i < 24; i++) begin
            c = '0;
            c.op = csb_op_type'(5'h08 + 5'(i / 2));
            c.bit_sel = 3'h7;
            c.offset = i[0] ? 7'h40 : 7'h3F;
            set_state(16'h0100, i[0] ? 8'h0A : 8'h8D);
            tk = csb_br_taken(c.op, c.bit_sel, exp_fl);
            exp_pc = exp_pc + PC_STEP + (tk ? {{9{c.offset[6]}}, c.offset} : 16'h0000);
            run(c, tk);
        end
        for (i = 0; i < 2; i++) begin
            host_wr(8'h02, 8'h11);
            set_state(16'h0200, i[0] ? 8'h00 : 8'h02);
            c = '0;
            c.op = op_branch_when_zero;
            c.offset = 7'h05;
            take_cmd(c);
            c = '0;
            c.op = op_compare_immediate;
            c.rd = 5'h02;
            c.imm = 8'h12;
            take_cmd(c);
            cmd_valid <= 1'h0;
            #1;
            n = int'(exec_done === 1'h1);
            repeat (4) begin
                @(posedge sys_clk);
                #1;
                n += int'(exec_done === 1'h1);
            end
            `CSB_CHK(n, i + 1, "executions")
            `CSB_CHK(pc_out, i[0] ? 16'h0202 : 16'h0206, "pair pc")
            `CSB_CHK(flags_out & 8'hEF, i[0] ? 8'h25 : 8'h02, "pair flags")
            @(posedge sys_clk);
        end
        end_of_test();
    end
endmodule

bind csb_unit csb_unit_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .host(host), .host_rdata(host_rdata), .pc_out(pc_out), .flags_out(flags_out),
    .redirect(redirect), .exec_done(exec_done));
`default_nettype wire
